// [verilog/dma2_unit.sv]
// two-channel dma unit with ahb-lite register slave and system bus master
//
// Operation
// - two channels run on their own and use the shared bus like the cpu
// - status line is high during every dma bus cycle
// - 20-bit flat pointers; step acts on all twenty bits, io too
// - per side memory or io, inc/dec/hold; byte or word size
// - count drops by one after each transfer, byte or word
// - with terminate bit set, count reaching zero clears arm
// - a starting count of zero gives 65536 transfers
// - with terminate bit clear count wraps and synchronised transfers go on
// - pointers and counts need no defined reset value
// - terminal interrupt only with interrupt enable and terminate bit
// - armed channel transfers on each request, at once after arming
// - arm changes only with qualifier in the same write; reads zero
// - unsynchronised mode clears arm at zero count regardless
// - registers stay writable; new pointer used by next transfer
// - on simultaneous requests higher priority bit wins
// - equal priority alternates, starting with channel 1
// - synchronised modes alternate only on same-sample requests
// - fetch into hidden holding register then deposit to destination
// - nothing but reset separates fetch from deposit
// - requests from programming, request pins or timer
// - request pins are synchronised to the clock first
// - peak rates: one transfer per two bus cycles, dst mode slower
// - destination mode releases the bus for two clocks after a transfer
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module dma2_unit
   import dma2_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // shared system bus
   output logic             bus_req,
   input  wire logic        bus_gnt,
   output logic             bus_cyc,
   output logic [19:0]      bus_addr,
   output logic             bus_io,
   output logic             bus_write,
   output logic             bus_word,
   output logic [15:0]      bus_wdata,
   input  wire logic [15:0] bus_rdata,
   input  wire logic        bus_done,
   output logic             dma_cycle_status_line,
   // request sources
   input  wire logic        dma_request_pin_ch0,
   input  wire logic        dma_request_pin_ch1,
   input  wire logic        timer_tick,
   // terminal count interrupt
   output logic [1:0]       tc_irq,
   input  wire logic [1:0]  irq_ack
);

   // ==========================================================
   // state
   dma2_regs_t r_ff;
   dma2_regs_t nxt_r;
   logic [1:0] want;
   logic       pick;
   logic       wch;
   logic [1:0] syn_c;
   logic [14:0] ctl_c;

   // pointer step over all twenty bits
   function automatic logic [19:0] f_step
   (
      input logic [19:0] p,
      input logic [1:0]  m,
      input logic        w
   );
      logic [19:0] s;
      s = w ? STEP_WORD : STEP_BYTE;
      if (m == STP_INC)
      begin
         f_step = p + s;
      end
      else if (m == STP_DEC)
      begin
         f_step = p - s;
      end
      else
      begin
         f_step = p;
      end
   endfunction

   // ==========================================================
   // request qualification and arbitration
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         syn_c = r_ff.ctl[c][CTL_SYN+:2];
         want[c] = r_ff.ctl[c][CTL_ARM] &&
                   ((syn_c == SYN_NONE) ||
                    (((syn_c == SYN_SRC) || (syn_c == SYN_DST)) &&
                     r_ff.sy2[c]) ||
                    (r_ff.ctl[c][CTL_TMR] && r_ff.tmr[c]));
      end
      syn_c = SYN_NONE;
      if (want == 2'b11)
      begin
         if (r_ff.ctl[0][CTL_PRIO] != r_ff.ctl[1][CTL_PRIO])
         begin
            pick = r_ff.ctl[1][CTL_PRIO];
         end
         else
         begin
            pick = ~r_ff.last;
         end
      end
      else
      begin
         pick = want[1];
      end
   end

   // ==========================================================
   // next state
   always_comb
   begin
      nxt_r = r_ff;
      wch   = r_ff.aa[CH_BIT];
      ctl_c = r_ff.ctl[r_ff.cur];
      // two-flop synchroniser on the request pins
      nxt_r.sy1 = {dma_request_pin_ch1, dma_request_pin_ch0};
      nxt_r.sy2 = r_ff.sy1;
      // acknowledge drops the interrupt level
      nxt_r.irq = r_ff.irq & ~irq_ack;
      // address phase capture
      nxt_r.aw = 1'b0;
      if (hsel && htrans[1] && hready)
      begin
         nxt_r.aa = haddr[7:0];
         nxt_r.aw = hwrite;
      end
      // transfer sequencer
      case (r_ff.st)
         ST_IDLE:
         begin
            if ((|want) && bus_gnt)
            begin
               nxt_r.cur  = pick;
               nxt_r.last = pick;
               nxt_r.tmr[pick] = 1'b0;
               nxt_r.st   = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            if (bus_done)
            begin
               nxt_r.hold = bus_rdata;
               nxt_r.st   = ST_DEPO;
            end
         end
         ST_DEPO:
         begin
            if (bus_done)
            begin
               nxt_r.src[r_ff.cur] = f_step(r_ff.src[r_ff.cur],
                  ctl_c[CTL_SSTP+:2], ctl_c[CTL_WORD]);
               nxt_r.dst[r_ff.cur] = f_step(r_ff.dst[r_ff.cur],
                  ctl_c[CTL_DSTP+:2], ctl_c[CTL_WORD]);
               nxt_r.cnt[r_ff.cur] = r_ff.cnt[r_ff.cur] - CNT_ONE;
               if (r_ff.cnt[r_ff.cur] == CNT_ONE)
               begin
                  if (ctl_c[CTL_TC] || (ctl_c[CTL_SYN+:2] == SYN_NONE))
                  begin
                     nxt_r.ctl[r_ff.cur][CTL_ARM] = 1'b0;
                  end
                  if (ctl_c[CTL_TC] && ctl_c[CTL_INT])
                  begin
                     nxt_r.irq[r_ff.cur] = 1'b1;
                  end
               end
               if (ctl_c[CTL_SYN+:2] == SYN_DST)
               begin
                  nxt_r.gap = DST_GAP;
                  nxt_r.st  = ST_GAP;
               end
               else
               begin
                  nxt_r.st = ST_IDLE;
               end
            end
         end
         ST_GAP:
         begin
            nxt_r.gap = r_ff.gap - 2'h1;
            if (r_ff.gap == 2'h1)
            begin
               nxt_r.st = ST_IDLE;
            end
         end
         default:
         begin
            nxt_r.st = ST_IDLE;
         end
      endcase
      // register writes act after the sequencer
      if (r_ff.aw && (r_ff.aa[7:5] == 3'h0))
      begin
         case ({r_ff.aa[7:5], 1'b0, r_ff.aa[3:0]})
            OFS_SRC:
            begin
               nxt_r.src[wch] = hwdata[19:0];
            end
            OFS_DST:
            begin
               nxt_r.dst[wch] = hwdata[19:0];
            end
            OFS_CNT:
            begin
               nxt_r.cnt[wch] = hwdata[15:0];
            end
            OFS_CTL:
            begin
               // arm keeps the sequencer's result unless qualified
               nxt_r.ctl[wch] = {hwdata[CTL_W-1:CTL_QUAL+1], 1'b0,
                  (hwdata[CTL_QUAL] ? hwdata[CTL_ARM] : nxt_r.ctl[wch][CTL_ARM])};
               if (!hwdata[CTL_TMR])
               begin
                  nxt_r.tmr[wch] = 1'b0;
               end
            end
            default:
            begin
               nxt_r.ctl = nxt_r.ctl;
            end
         endcase
      end
      // timer request latch; a new tick beats a clear
      for (int c = 0; c < 2; c++)
      begin
         if (timer_tick && nxt_r.ctl[c][CTL_TMR])
         begin
            nxt_r.tmr[c] = 1'b1;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         r_ff <= '0;
      end
      else
      begin
         r_ff <= nxt_r;
      end
   end

   // ==========================================================
   // register read mux, zero-wait okay answers
   always_comb
   begin
      hreadyout = 1'b1;
      hresp     = 1'b0;
      hrdata    = 32'h0000_0000;
      if (r_ff.aa == OFS_STAT)
      begin
         hrdata[1:0] = {r_ff.ctl[1][CTL_ARM], r_ff.ctl[0][CTL_ARM]};
         hrdata[3:2] = r_ff.irq;
         hrdata[5:4] = r_ff.st;
         hrdata[6]   = r_ff.cur;
      end
      else if (r_ff.aa[7:5] == 3'h0)
      begin
         case ({r_ff.aa[7:5], 1'b0, r_ff.aa[3:0]})
            OFS_SRC:
            begin
               hrdata[19:0] = r_ff.src[r_ff.aa[CH_BIT]];
            end
            OFS_DST:
            begin
               hrdata[19:0] = r_ff.dst[r_ff.aa[CH_BIT]];
            end
            OFS_CNT:
            begin
               hrdata[15:0] = r_ff.cnt[r_ff.aa[CH_BIT]];
            end
            OFS_CTL:
            begin
               hrdata[CTL_W-1:0] = r_ff.ctl[r_ff.aa[CH_BIT]];
            end
            default:
            begin
               hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ==========================================================
   // system bus drive; the bus is held from fetch through deposit
   always_comb
   begin
      bus_req   = ((r_ff.st == ST_IDLE) && (|want)) ||
                  (r_ff.st == ST_FETCH) || (r_ff.st == ST_DEPO);
      bus_cyc   = (r_ff.st == ST_FETCH) || (r_ff.st == ST_DEPO);
      bus_write = (r_ff.st == ST_DEPO);
      bus_addr  = bus_write ? r_ff.dst[r_ff.cur] : r_ff.src[r_ff.cur];
      bus_io    = bus_write ? r_ff.ctl[r_ff.cur][CTL_DIO] :
                              r_ff.ctl[r_ff.cur][CTL_SIO];
      bus_word  = r_ff.ctl[r_ff.cur][CTL_WORD];
      bus_wdata = r_ff.hold;
      dma_cycle_status_line = bus_cyc;
      tc_irq    = r_ff.irq;
   end

   // hsize unused: only whole-word access is decoded
endmodule
`default_nettype wire

// [verilog/dma2_pkg.sv]
// constants, field layout and state types of the two-channel dma unit
`default_nettype none
package dma2_pkg;
   // ==========================================================
   // register map: channel c at c*0x10, status above them
   localparam logic [7:0] OFS_SRC  = 8'h00;
   localparam logic [7:0] OFS_DST  = 8'h04;
   localparam logic [7:0] OFS_CNT  = 8'h08;
   localparam logic [7:0] OFS_CTL  = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h20;
   localparam int         CH_BIT   = 4;
   // ==========================================================
   // control register fields
   localparam int CTL_ARM  = 0;
   localparam int CTL_QUAL = 1;
   localparam int CTL_TC   = 2;
   localparam int CTL_INT  = 3;
   localparam int CTL_WORD = 4;
   localparam int CTL_TMR  = 5;
   localparam int CTL_SYN  = 6;
   localparam int CTL_PRIO = 8;
   localparam int CTL_SSTP = 9;
   localparam int CTL_SIO  = 11;
   localparam int CTL_DSTP = 12;
   localparam int CTL_DIO  = 14;
   localparam int CTL_W    = 15;
   localparam logic [14:0] CTL_RST = 15'h0000;
   // ==========================================================
   // synchronisation and pointer step codes
   localparam logic [1:0] SYN_NONE = 2'h0;
   localparam logic [1:0] SYN_SRC  = 2'h1;
   localparam logic [1:0] SYN_DST  = 2'h2;
   localparam logic [1:0] STP_INC  = 2'h1;
   localparam logic [1:0] STP_DEC  = 2'h2;
   localparam logic [19:0] STEP_BYTE = 20'h0_0001;
   localparam logic [19:0] STEP_WORD = 20'h0_0002;
   localparam logic [15:0] CNT_ONE   = 16'h0001;
   // bus release after a destination-synchronised transfer, clocks
   localparam logic [1:0]  DST_GAP   = 2'h2;
   // ==========================================================
   // state
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_DEPO  = 2'b10,
      ST_GAP   = 2'b11
   } dma2_state_t;

   typedef struct packed
   {
      dma2_state_t       st;
      logic [1:0]        gap;
      logic              cur;
      logic              last;
      logic [1:0][19:0]  src;
      logic [1:0][19:0]  dst;
      logic [1:0][15:0]  cnt;
      logic [1:0][14:0]  ctl;
      logic [15:0]       hold;
      logic [1:0]        sy1;
      logic [1:0]        sy2;
      logic [1:0]        tmr;
      logic [1:0]        irq;
      logic              aw;
      logic [7:0]        aa;
   } dma2_regs_t;
endpackage
`default_nettype wire

// [sim/dma2_bus_model.sv]
// system bus memory model answering dma cycles
`timescale 1ns/10ps
`default_nettype none
module dma2_bus_model
(
   // master side
   input  wire logic        hclk,
   input  wire logic        bus_req,
   input  wire logic        bus_cyc,
   input  wire logic        slow,
   // answers
   output logic             bus_gnt,
   output logic             bus_done,
   output logic [15:0]      bus_rdata
);
   logic [1:0]  wt;
   logic [15:0] pat;
   logic        dn;
   initial
   begin
      bus_gnt = 0;
      bus_done = 0;
      bus_rdata = 0;
      wt = 0;
      pat = 16'h5A3C;
   end
   // grant one clock late; cycles end at once or after three waits
   always @(posedge hclk)
   begin
      dn = bus_cyc && !bus_done && (wt == 2'h3 || !slow);
      bus_gnt <= bus_req;
      bus_done <= dn;
      wt <= (bus_cyc && !bus_done) ? wt + 2'h1 : 2'h0;
      pat <= pat + 16'h3D27;
      bus_rdata <= dn ? pat : ~bus_rdata;   // toggles when not answering
   end
endmodule
`default_nettype wire

// [sim/dma2_unit_assertions.sv]
// port checker of the two-channel dma unit
`timescale 1ns/10ps
`default_nettype none
module dma2_unit_chk
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // system bus and interrupts
   input wire logic        bus_req,
   input wire logic        bus_gnt,
   input wire logic        bus_cyc,
   input wire logic [19:0] bus_addr,
   input wire logic        bus_write,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic        bus_done,
   input wire logic        dma_cycle_status_line,
   input wire logic [1:0]  tc_irq,
   input wire logic [1:0]  irq_ack
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // bus cycles
   a_status_line_eq: assert property (dma_cycle_status_line == bus_cyc)
      else $error("status line differs from dma cycle");
   a_cyc_under_req: assert property (bus_cyc |-> bus_req)
      else $error("dma cycle without bus request");
   a_fetch_after_gnt: assert property ($rose(bus_cyc) |-> !bus_write && $past(bus_gnt))
      else $error("cycle not a fetch after grant");
   a_depo_follows: assert property (bus_cyc && !bus_write && bus_done |=>
      bus_cyc && bus_write && bus_wdata == $past(bus_rdata))
      else $error("deposit does not follow fetch");
   a_addr_holds: assert property (bus_cyc && !bus_done |=>
      $stable(bus_addr) && $stable(bus_write))
      else $error("cycle changed before done");
   a_depo_ends: assert property (bus_cyc && bus_write && bus_done |=> !bus_cyc)
      else $error("no idle clock after deposit");
   // ==========================================================
   // terminal interrupt
   a_irq_holds: assert property ((tc_irq & ~irq_ack) != 2'h0 |=>
      (tc_irq & $past(tc_irq & ~irq_ack)) == $past(tc_irq & ~irq_ack))
      else $error("interrupt dropped without ack");
   a_irq_cause: assert property ((tc_irq & ~$past(tc_irq)) != 2'h0 |->
      $past(bus_cyc && bus_write && bus_done))
      else $error("interrupt not at deposit end");
   c_fetch: cover property ($rose(bus_cyc));
   c_depo: cover property (bus_cyc && bus_write && bus_done);
   c_irq: cover property (tc_irq != 2'h0);
endmodule
bind dma2_unit dma2_unit_chk u_chk (.hclk, .hresetn, .bus_req, .bus_gnt, .bus_cyc,
   .bus_addr, .bus_write, .bus_wdata, .bus_rdata, .bus_done, .dma_cycle_status_line,
   .tc_irq, .irq_ack);
`default_nettype wire

// [sim/dma2_unit_tb.sv]
// self-checking testbench of the two-channel dma unit
`timescale 1ns/10ps
`default_nettype none
module dma2_unit_tb
   import dma2_pkg::*;
;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, slow, bus_req, bus_gnt;
   logic        bus_cyc, bus_io, bus_write, bus_word, bus_done, dma_cycle_status_line;
   logic        dma_request_pin_ch0, dma_request_pin_ch1, c, w, tc, timer_tick;
   logic [1:0]  htrans, irq_ack, tc_irq, ss, ds;
   logic [15:0] bus_wdata, bus_rdata, n;
   logic [19:0] bus_addr, s, d;
   logic [31:0] haddr, hwdata, hrdata, rd, seed, r, v;
   int          err_count, n_checks;
   dma2_unit DUT (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bus_req, .bus_gnt,
      .bus_cyc, .bus_addr, .bus_io, .bus_write, .bus_word, .bus_wdata, .bus_rdata,
      .bus_done, .dma_cycle_status_line, .dma_request_pin_ch0, .dma_request_pin_ch1,
      .timer_tick, .tc_irq, .irq_ack);
   dma2_bus_model PEER (.hclk, .bus_req, .bus_cyc, .slow, .bus_gnt, .bus_done,
      .bus_rdata);
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] ra(input logic ch, input logic [7:0] o);
      return {3'h0, ch, 4'h0} | o;
   endfunction
   function automatic logic [31:0] nxt(input logic [19:0] p, input logic [1:0] m,
      input logic wd, input logic [15:0] k);
      logic [19:0] st;
      logic [19:0] res;
      st = (wd ? STEP_WORD : STEP_BYTE) * 20'(k);
      // pointers wrap within twenty bits
      res = m == STP_INC ? p + st : m == STP_DEC ? p - st : p;
      return 32'(res);
   endfunction
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_clear(input logic ch);
      int i;
      for (i = 0; i < 300; i++)
      begin
         ahb(0, OFS_STAT, 0);
         if (rd[ch] === 1'h0)
            break;
      end
      chk(32'(i < 300), 32'h1);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // clock, watchdog and test sequence
   initial
   begin
      hclk = 0;
      forever #2 hclk = ~hclk;
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      err_count++;
      stop_test();
   end
   initial
   begin
      {hresetn, hwrite, slow, dma_request_pin_ch0, dma_request_pin_ch1, timer_tick} = 0;
      {htrans, irq_ack, haddr, hwdata} = 0;
      seed = 32'h0001_55C7;
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      ahb(1, ra(0, OFS_SRC), 32'hFFFF_FFFF);
      ahb(0, ra(0, OFS_SRC), 0);
      chk(rd, 32'h000F_FFFF);
      ahb(1, ra(0, OFS_CTL), 32'h1);
      ahb(0, OFS_STAT, 0);
      chk(rd & 32'h3, 32'h0);
      ahb(0, 8'h30, 0);
      chk(rd, 32'h0);
      // random unsynchronised runs with a 20-bit wrap corner first
      for (int k = 0; k < 4; k++)
      begin
         r = rnd();
         {c, w, tc, ds} = r[4:0];
         ss = k == 0 ? STP_INC : r[6:5];
         n = 16'(r[8:7]) + 16'h1;
         slow <= r[9];
         s = k == 0 ? 20'hF_FFFF : 20'(rnd());
         d = 20'(rnd());
         ahb(1, ra(c, OFS_SRC), 32'(s));
         ahb(1, ra(c, OFS_DST), 32'(d));
         ahb(1, ra(c, OFS_CNT), 32'(n));
         ahb(1, ra(c, OFS_CTL), 32'h3 | 32'(tc) << CTL_TC | 32'h1 << CTL_INT
            | 32'(w) << CTL_WORD | 32'(ss) << CTL_SSTP | 32'(ds) << CTL_DSTP);
         wait_clear(c);
         ahb(0, ra(c, OFS_SRC), 0);
         chk(rd, nxt(s, ss, w, n));
         ahb(0, ra(c, OFS_DST), 0);
         chk(rd, nxt(d, ds, w, n));
         ahb(0, ra(c, OFS_CNT), 0);
         chk(rd, 32'h0);
         chk(32'(tc_irq), 32'(tc) << c);
         irq_ack <= 2'h3;
         @(posedge hclk);
         irq_ack <= 2'h0;
         @(posedge hclk);
         chk(32'(tc_irq), 32'h0);
      end
      // destination-synchronised run ending at terminal count
      dma_request_pin_ch1 <= 1;
      ahb(1, ra(1, OFS_DST), 32'h100);
      ahb(1, ra(1, OFS_CNT), 32'h2);
      ahb(1, ra(1, OFS_CTL), 32'h3 | 32'h1 << CTL_TC | 32'h1 << CTL_INT
         | 32'(SYN_DST) << CTL_SYN | 32'(STP_INC) << CTL_DSTP);
      wait_clear(1);
      dma_request_pin_ch1 <= 0;
      ahb(0, ra(1, OFS_DST), 0);
      chk(rd, 32'h102);
      chk(32'(tc_irq), 32'h2);
      // source-synchronised count wraps and keeps the channel armed
      dma_request_pin_ch0 <= 1;
      v = 32'h3 | 32'(SYN_SRC) << CTL_SYN;
      ahb(1, ra(0, OFS_CNT), 32'h1);
      ahb(1, ra(0, OFS_CTL), v);
      rd = 0;
      for (int i = 0; i < 300 && rd[15] !== 1'h1; i++)
         ahb(0, ra(0, OFS_CNT), 0);
      chk(32'(rd[15]), 32'h1);
      ahb(0, ra(0, OFS_CTL), 0);
      chk(rd, v & ~32'h2);
      ahb(1, ra(0, OFS_CTL), 32'h2);
      dma_request_pin_ch0 <= 0;
      ahb(0, OFS_STAT, 0);
      chk(rd & 32'h1, 32'h0);
      // timer-requested run on channel 1 with no pin request
      timer_tick <= 1;
      ahb(1, ra(1, OFS_CNT), 32'h2);
      ahb(1, ra(1, OFS_CTL), 32'h3 | 32'h1 << CTL_TC | 32'h1 << CTL_TMR | 32'h3 << CTL_SYN);
      wait_clear(1);
      timer_tick <= 0;
      ahb(0, ra(1, OFS_CNT), 0);
      chk(rd, 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
